// File: hw/asrc_ctrl.sv
// host controller that drives an asynchronous 512K x 8 static memory
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - write strobe high on every read
// - never drive data while memory reads
// - sequence drivers to avoid data contention
// - address valid before write start, held
// - address stable through write recovery
// - write pulse at least 12 ns here
module asrc_ctrl
	import asrc_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// user request side
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire asrc_req_s REQ,
	output logic RD_VALID,
	output logic [DATA_W-1:0] RD_DATA,
	// memory pins
	output logic [ADDR_W-1:0] MEM_ADDR,
	output logic MEM_CS_N,
	output logic MEM_WE_N,
	output logic MEM_OE_N,
	input wire logic [DATA_W-1:0] MEM_DQ_I,
	output logic [DATA_W-1:0] MEM_DQ_O,
	output logic MEM_DQ_OE
);
	asrc_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	asrc_strobe_s stb_q, stb_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdat_q, wdat_d;
	logic dq_oe_q, dq_oe_d;
	logic rd_valid_q, rd_valid_d;
	logic [DATA_W-1:0] rd_data_q, rd_data_d;
	logic [DATA_W-1:0] dq_sync;
	logic cnt_done;
	// decoded request and phase ends
	logic take;
	logic take_wr;
	logic take_rd;
	logic rd_end;
	logic wset_end;
	logic wp_end;
	logic rec_end;
	logic stb_busy;

	// data lines pass two flops before use
	asrc_sync #(.W(DATA_W)) u_sync (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.d(MEM_DQ_I),
		.q(dq_sync)
	);

	// request hand-off and the end of each timed phase
	assign cnt_done = (cnt_q == CNT_ZERO);
	assign REQ_READY = (state_q == ST_IDLE);
	assign take = REQ_VALID && REQ_READY;
	assign take_wr = take && REQ.write;
	assign take_rd = take && !REQ.write;
	assign rd_end = (state_q == ST_RD) && cnt_done;
	assign wset_end = (state_q == ST_WSETUP) && cnt_done;
	assign wp_end = (state_q == ST_WPULSE) && cnt_done;
	assign rec_end = (state_q == ST_REC) && cnt_done;
	assign stb_busy = (state_q == ST_RD) || (state_q == ST_WSETUP) || (state_q == ST_WPULSE);

	// sequencer: which phase comes next and how long it lasts
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_done ? cnt_q : cnt_q - CNT_STEP;
		unique case (state_q)
			ST_IDLE: begin
				if (take_wr) begin
					// address and data settle with select low, write strobe and output enable high first
					cnt_d = SETUP_CNT;
					state_d = ST_WSETUP;
				end else if (take_rd) begin
					cnt_d = RD_CNT + SYNC_CNT; // access time plus two sync stages
					state_d = ST_RD;
				end
			end
			ST_RD: begin
				if (cnt_done) begin
					cnt_d = REC_CNT;
					state_d = ST_REC; // let memory float before next drive
				end
			end
			ST_WSETUP: begin
				if (cnt_done) begin
					cnt_d = WP_CNT;
					state_d = ST_WPULSE;
				end
			end
			ST_WPULSE: begin
				if (cnt_done) begin
					cnt_d = REC_CNT; // address and data held one more phase
					state_d = ST_REC;
				end
			end
			ST_REC: begin
				if (cnt_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				// an illegal code falls back to idle
				cnt_d = CNT_ZERO;
				state_d = ST_IDLE;
			end
		endcase
	end

	// register sequencer state
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// strobes: select first, write strobe one phase later, all rise together
	always_comb begin
		stb_d = stb_q;
		if (take_wr) begin
			stb_d = STB_WSET; // select with write strobe and output enable high
		end else if (take_rd) begin
			stb_d = STB_READ; // write strobe stays high on a read
		end else if (wset_end) begin
			stb_d = STB_WRITE; // write strobe falls last, output enable held high
		end else if (rd_end || wp_end) begin
			stb_d = STB_IDLE; // ends the access; memory floats again
		end else if (!stb_busy) begin
			stb_d = STB_IDLE;
		end
	end

	// register strobes; all high out of reset
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			stb_q <= STB_IDLE;
		end else begin
			stb_q <= stb_d;
		end
	end

	// address, write data and our own driver enable
	always_comb begin
		addr_d = addr_q;
		wdat_d = wdat_q;
		dq_oe_d = dq_oe_q;
		if (take) begin
			addr_d = REQ.addr; // held until the next request
		end
		if (take_wr) begin
			wdat_d = REQ.wdata;
			dq_oe_d = 1'b1; // memory outputs are off; drive shared lines
		end else if (rec_end || state_q == ST_IDLE) begin
			dq_oe_d = 1'b0; // never fight the memory on a read
		end
	end

	// register address, write data and driver enable
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			addr_q <= ADDR_RST;
			wdat_q <= DATA_RST;
			dq_oe_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			dq_oe_q <= dq_oe_d;
		end
	end

	// read return: take the synchronised byte when the wait runs out
	always_comb begin
		rd_valid_d = 1'b0;
		rd_data_d = rd_data_q;
		if (rd_end) begin
			rd_valid_d = 1'b1; // one-cycle pulse
			rd_data_d = dq_sync; // byte of the address just presented
		end
	end

	// register read return
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= DATA_RST;
		end else begin
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
		end
	end

	// pins straight from flops
	assign MEM_ADDR = addr_q;
	assign MEM_CS_N = stb_q.cs_n;
	assign MEM_WE_N = stb_q.we_n;
	assign MEM_OE_N = stb_q.oe_n;
	assign MEM_DQ_O = wdat_q;
	assign MEM_DQ_OE = dq_oe_q;
	assign RD_VALID = rd_valid_q;
	assign RD_DATA = rd_data_q;
endmodule
`default_nettype wire

// File: hw/asrc_pkg.sv
// package with pin layout, timing constants and types for the static memory controller
package asrc_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 20;
	// timing figures of the fastest grade, in ns
	localparam int T_RC_NS = 12;
	localparam int T_AA_NS = 12;
	localparam int T_OE_NS = 6;
	localparam int T_HZ_NS = 6;
	localparam int T_AS_NS = 0;
	localparam int T_WP_NS = 8;
	localparam int T_WP1_NS = 12;
	localparam int T_WR_NS = 0;
	localparam int T_DW_NS = 6;
	localparam int T_DH_NS = 0;
	localparam int T_WHZ_NS = 6;
	// least times round up, never below one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RD_CYC = cyc_min(T_AA_NS + T_OE_NS);
	localparam int WP_CYC = cyc_min(T_WP1_NS);
	localparam int SETUP_CYC = cyc_min(T_AS_NS);
	localparam int REC_CYC = cyc_min(T_WR_NS + T_HZ_NS);
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC - 1);
	localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(REC_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;
	// extra wait of a read for the two synchroniser stages on the data lines
	localparam logic [CNT_W-1:0] SYNC_CNT = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	// strobe levels on the pins, active low
	typedef struct packed {
		logic cs_n;
		logic we_n;
		logic oe_n;
	} asrc_strobe_s;
	localparam asrc_strobe_s STB_IDLE = 3'h7;
	localparam asrc_strobe_s STB_READ = 3'h2;
	localparam asrc_strobe_s STB_WSET = 3'h3;
	localparam asrc_strobe_s STB_WRITE = 3'h1;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
	} asrc_req_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD = 3'b001,
		ST_WSETUP = 3'b010,
		ST_WPULSE = 3'b011,
		ST_REC = 3'b100
	} asrc_state_e;
endpackage

// File: hw/asrc_sync.sv
// two-stage synchroniser for the data lines coming back from the memory
`timescale 1ns/1ns
`default_nettype none
module asrc_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous in, synchronous out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_d;
	// next values: first stage is read only by second
	always_comb begin
		s1_d = d;
		s2_d = s1_q;
	end
	// register both stages
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end
	assign q = s2_q;
endmodule
`default_nettype wire

// File: test/asrc_ctrl_sva.sv
// pin checker for the static memory controller
`timescale 1ns/1ns
`default_nettype none
module asrc_ctrl_sva import asrc_pkg::*; (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// request side
	input wire logic REQ_READY,
	input wire logic RD_VALID,
	// memory pins
	input wire logic MEM_CS_N,
	input wire logic MEM_WE_N,
	input wire logic MEM_OE_N,
	input wire logic MEM_DQ_OE,
	input wire logic [ADDR_W-1:0] MEM_ADDR
);
	int we_low_cnt;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// count of clock edges at which the write strobe was seen low
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN || MEM_WE_N) begin
			we_low_cnt <= 0;
		end else begin
			we_low_cnt <= we_low_cnt + 1;
		end
	end
	// strobe, address and handshake relations
	a_rd_we_hi: assert property (!MEM_OE_N |-> MEM_WE_N) else $error("we low in read");
	a_no_clash: assert property (!MEM_CS_N && !MEM_OE_N |-> !MEM_DQ_OE) else $error("clash");
	a_drv_order: assert property ($rose(MEM_DQ_OE) |-> MEM_OE_N && $past(MEM_OE_N))
		else $error("drive order");
	a_addr_hold: assert property (!MEM_WE_N |-> $stable(MEM_ADDR) && !MEM_CS_N)
		else $error("addr moved");
	a_addr_rec: assert property ($rose(MEM_WE_N) |=> $stable(MEM_ADDR)) else $error("recovery");
	a_wr_pulse: assert property ($rose(MEM_WE_N) |-> we_low_cnt >= WP_CYC)
		else $error("short pulse");
	a_wr_oe_hi: assert property (!MEM_WE_N |-> MEM_OE_N) else $error("oe low in write");
	a_rd_pulse: assert property (RD_VALID |=> !RD_VALID) else $error("long read valid");
	a_busy_ready: assert property (!MEM_CS_N |-> !REQ_READY) else $error("ready while busy");
	c_read: cover property (!MEM_CS_N && !MEM_OE_N);
	c_write: cover property ($fell(MEM_WE_N));
	c_b2b: cover property ($rose(MEM_WE_N) ##[1:3] !MEM_OE_N);
	c_rd_ret: cover property (RD_VALID);
endmodule
bind asrc_ctrl asrc_ctrl_sva i_sva(.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REQ_READY(REQ_READY),
	.RD_VALID(RD_VALID), .MEM_CS_N(MEM_CS_N), .MEM_WE_N(MEM_WE_N), .MEM_OE_N(MEM_OE_N),
	.MEM_DQ_OE(MEM_DQ_OE), .MEM_ADDR(MEM_ADDR));
`default_nettype wire

// File: test/asrc_mem_model.sv
// behavioural model of the asynchronous static memory
`timescale 1ns/1ns
`default_nettype none
module asrc_mem_model import asrc_pkg::*; #(parameter int DLY = T_AA_NS) (
	// address and strobes
	input wire logic [ADDR_W-1:0] addr,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic oe_n,
	// shared data lines
	input wire logic dq_oe,
	input wire logic [DATA_W-1:0] dq_o,
	output logic [DATA_W-1:0] dq
);
	logic [DATA_W-1:0] mem [bit [ADDR_W-1:0]]; // byte per address, no clock
	logic [DATA_W-1:0] rd, last = 8'h00;
	logic act = 0;
	// drives only when read mode, off at once, on after delay
	wire drv = !cs_n && we_n && !oe_n;
	assign dq = dq_oe ? dq_o : drv ? rd : ~last; // shared lines
	// data of the new address after access delay
	always @(addr, oe_n, cs_n) rd <= #DLY mem.exists(addr) ? mem[addr] : ~last;
	always @(negedge drv) last = rd;
	// write over strobe overlap, captured at the end
	always @(cs_n, we_n) begin
		if (act && (cs_n || we_n)) mem[addr] = dq;
		act = !cs_n && !we_n;
	end
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the static memory controller
`timescale 1ns/1ns
`default_nettype none
module tb import asrc_pkg::*; ;
	logic CORE_CLK = 0, RESETN = 0, REQ_VALID = 0, REQ_READY, RD_VALID;
	logic MEM_CS_N, MEM_WE_N, MEM_OE_N, MEM_DQ_OE;
	asrc_req_s REQ = '0;
	logic [DATA_W-1:0] RD_DATA, MEM_DQ_I, MEM_DQ_O;
	logic [ADDR_W-1:0] MEM_ADDR, ad [8];
	logic [DATA_W-1:0] sh [bit [ADDR_W-1:0]], exp_q [$];
	int err_total = 0, comparisons = 0, seed = 72, n;
	asrc_ctrl i_dut(.CORE_CLK, .RESETN, .REQ_VALID, .REQ_READY, .REQ, .RD_VALID, .RD_DATA,
		.MEM_ADDR, .MEM_CS_N, .MEM_WE_N, .MEM_OE_N, .MEM_DQ_I, .MEM_DQ_O, .MEM_DQ_OE);
	asrc_mem_model i_mem(.addr(MEM_ADDR), .cs_n(MEM_CS_N), .we_n(MEM_WE_N), .oe_n(MEM_OE_N),
		.dq_oe(MEM_DQ_OE), .dq_o(MEM_DQ_O), .dq(MEM_DQ_I));
	initial forever #10 CORE_CLK = ~CORE_CLK;
	// compare and count
	task chk(input logic [DATA_W-1:0] s, e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task print_verdict;
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// hold a request until taken, note the byte a read must return
	task op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge CORE_CLK);
		REQ_VALID = 1;
		REQ = '{a, d, w};
		for (n = 0; REQ_READY !== 1'b1 && n < 20; n++) @(negedge CORE_CLK);
		if (n == 20) err_total++;
		@(posedge CORE_CLK);
		if (w) sh[a] = d;
		else exp_q.push_back(sh[a]);
		@(negedge CORE_CLK);
		chk(8'(REQ_READY), 8'h00);
	endtask
	// each returned byte against the oldest note, looked at mid-cycle
	always @(negedge CORE_CLK) if (RD_VALID === 1'b1) chk(RD_DATA, exp_q.pop_front());
	initial begin
		repeat (12) @(negedge CORE_CLK);
		RESETN = 1;
		op(1, 19'h00000, 8'hA5);
		op(1, 19'h7FFFF, 8'h5A);
		op(0, 19'h7FFFF, 8'h00);
		op(0, 19'h00000, 8'h00);
		foreach (ad[i]) begin
			ad[i] = 19'($random(seed));
			op(1, ad[i], 8'($random(seed)));
		end
		repeat (60) op(1'($random(seed)), ad[3'($random(seed))], 8'($random(seed)));
		@(negedge CORE_CLK);
		REQ_VALID = 0;
		repeat (12) @(negedge CORE_CLK);
		chk(8'(exp_q.size()), 8'h00);
		print_verdict;
	end
	initial begin
		#100000;
		err_total++;
		print_verdict;
	end
endmodule
`default_nettype wire
